/* rtl/fps_flash.sv */
// Program flash self-write sequencer with its own word array.
// Assumes the core presents at most one register access per clock.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fps_flash #(
  parameter int WRITE_CYCLES = fps_pkg::WRITE_CYCLES,
  parameter int PWRT_CYCLES  = fps_pkg::PWRT_CYCLES,
  parameter int SEGMENTS     = 4
) (
  // Clock and power-up reset
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  // Core side
  fps_if.dev                       bus,
  // Protection and status
  input  wire logic [SEGMENTS-1:0] protect_seg_i,
  output logic                     busy_o,
  output logic                     pwrt_done_o
);

  localparam int AW = fps_pkg::ADDR_W;
  localparam int SW = $clog2(SEGMENTS);

  // ========================================================================
  // State.
  logic [fps_pkg::WORD_W-1:0] mem_q [2**AW];
  logic [fps_pkg::WORD_W-1:0] buf_q [fps_pkg::BLOCK_WORDS];
  logic                       rd_q;
  logic                       rd_phase_q;
  logic                       wr_q;
  logic                       write_permission_q;
  logic [1:0]                 key_q;
  logic [7:0]                 adrl_q;
  logic [1:0]                 adrh_q;
  logic [7:0]                 datl_q;
  logic [5:0]                 dath_q;
  logic [1:0]                 setup_q;
  logic [fps_pkg::CNT_W-1:0]  long_q;
  logic [fps_pkg::CNT_W-1:0]  pwrt_q;
  logic                       stall_q;
  logic                       squash_q;
  logic [7:0]                 rdata_q;
  logic                       rvalid_q;

  logic          taken;
  logic          wr_ctrl;
  logic [AW-1:0] addr;
  logic          wr_go;
  logic          long_end;

  // Accesses during a discarded or stalled cycle do not exist for the core.
  assign taken    = !stall_q && !squash_q;
  assign wr_ctrl  = taken && bus.acc_we && bus.acc_reg == fps_pkg::REG_CTRL;
  assign addr     = {adrh_q, adrl_q};
  assign wr_go    = wr_ctrl && bus.acc_wdata[fps_pkg::CTRL_WR_BIT] && !wr_q && !rd_q
                    && write_permission_q && key_q == 2'h2 && pwrt_q == '0;
  assign long_end = stall_q && long_q == '0;

  function automatic logic seg_open(input logic [AW-1:0] a,
                                    input logic [SEGMENTS-1:0] prot);
    seg_open = !prot[a[AW-1 -: SW]];
  endfunction : seg_open

  // ========================================================================
  // Power-up timer.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pwrt_q <= fps_pkg::CNT_W'(PWRT_CYCLES);
    end else if (pwrt_q != '0) begin
      pwrt_q <= pwrt_q - 1'b1;
    end
  end

  // ========================================================================
  // Write permission and unlock key.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      write_permission_q <= 1'b0;
    end else if (wr_ctrl) begin
      write_permission_q <= bus.acc_wdata[fps_pkg::CTRL_WRITE_PERMISSION_BIT];
    end
  end

  // The key is only good for the write access straight after it.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      key_q <= 2'h0;
    end else if (taken && bus.acc_we) begin
      if (bus.acc_reg == fps_pkg::REG_KEY && bus.acc_wdata == fps_pkg::KEY_FIRST) begin
        key_q <= 2'h1;
      end else if (bus.acc_reg == fps_pkg::REG_KEY && key_q == 2'h1
                   && bus.acc_wdata == fps_pkg::KEY_SECOND) begin
        key_q <= 2'h2;
      end else begin
        key_q <= 2'h0;
      end
    end
  end

  // ========================================================================
  // Address registers.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      adrl_q <= 8'h00;
      adrh_q <= 2'h0;
    end else if (taken && bus.acc_we) begin
      if (bus.acc_reg == fps_pkg::REG_ADRL) begin
        adrl_q <= bus.acc_wdata;
      end
      if (bus.acc_reg == fps_pkg::REG_ADRH) begin
        adrh_q <= bus.acc_wdata[1:0];
      end
    end
  end

  // ========================================================================
  // Read sequence: the cycle after the trigger runs, the next is squashed.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_q       <= 1'b0;
      rd_phase_q <= 1'b0;
      squash_q   <= 1'b0;
    end else if (rd_q) begin
      rd_phase_q <= 1'b1;
      squash_q   <= !rd_phase_q;
      if (rd_phase_q) begin
        rd_q <= 1'b0;
      end
    end else if (wr_ctrl && bus.acc_wdata[fps_pkg::CTRL_RD_BIT] && !wr_q) begin
      rd_q       <= 1'b1;
      rd_phase_q <= 1'b0;
    end
  end

  // Data registers hold until a read lands or software rewrites them.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      datl_q <= 8'h00;
      dath_q <= 6'h00;
    end else if (rd_q && rd_phase_q) begin
      datl_q <= mem_q[addr][7:0];
      dath_q <= mem_q[addr][13:8];
    end else if (taken && bus.acc_we) begin
      if (bus.acc_reg == fps_pkg::REG_DATL) begin
        datl_q <= bus.acc_wdata;
      end
      if (bus.acc_reg == fps_pkg::REG_DATH) begin
        dath_q <= bus.acc_wdata[5:0];
      end
    end
  end

  // ========================================================================
  // Write sequence.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_q    <= 1'b0;
      setup_q <= 2'h0;
      stall_q <= 1'b0;
      long_q  <= '0;
    end else if (wr_go) begin
      wr_q    <= 1'b1;
      setup_q <= 2'(fps_pkg::SETUP_CYCLES);
    end else if (setup_q != 2'h0) begin
      setup_q <= setup_q - 1'b1;
      if (setup_q == 2'h1) begin
        if (adrl_q[1:0] == 2'h3) begin
          stall_q <= 1'b1;
          long_q  <= fps_pkg::CNT_W'(WRITE_CYCLES - 1);
        end else begin
          wr_q <= 1'b0;
        end
      end
    end else if (stall_q) begin
      if (long_q == '0) begin
        stall_q <= 1'b0;
        wr_q    <= 1'b0;
      end else begin
        long_q <= long_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_go) begin
      buf_q[adrl_q[1:0]] <= {dath_q, datl_q};
    end
  end

  // Erase the 16-word block, then lay the 4 buffered words into it.
  always_ff @(posedge clock_i) begin
    if (long_end && seg_open(addr, protect_seg_i)) begin
      for (int i = 0; i < fps_pkg::ERASE_WORDS; i++) begin
        mem_q[{addr[AW-1:4], 4'(i)}] <= fps_pkg::ERASED_WORD;
      end
      for (int i = 0; i < fps_pkg::BLOCK_WORDS; i++) begin
        mem_q[{addr[AW-1:2], 2'(i)}] <= buf_q[i];
      end
    end
  end

  // ========================================================================
  // Register read port, answered one cycle after the request.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= taken && bus.acc_re;
      unique case (bus.acc_reg)
        fps_pkg::REG_CTRL: rdata_q <= {5'h00, write_permission_q, wr_q, rd_q};
        fps_pkg::REG_ADRL: rdata_q <= adrl_q;
        fps_pkg::REG_ADRH: rdata_q <= {6'h00, adrh_q};
        fps_pkg::REG_DATL: rdata_q <= datl_q;
        fps_pkg::REG_DATH: rdata_q <= {2'h0, dath_q};
        default:           rdata_q <= 8'h00;
      endcase
    end
  end

  // ========================================================================
  // Outputs.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      busy_o      <= 1'b0;
      pwrt_done_o <= 1'b0;
    end else begin
      busy_o      <= wr_q || rd_q;
      pwrt_done_o <= pwrt_q == '0;
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign bus.stall  = stall_q;
  assign bus.squash = squash_q;

endmodule : fps_flash
`default_nettype wire

/* inc/fps_pkg.sv */
// Constants shared by both ends of the program flash self-write sequencer.
// Assumes a single 200 MHz instruction clock common to both ends.
// ==========================================================================
// What this block does
// - Read trigger starts two-cycle read, hardware clears
// - Software writes only set the read trigger
// - Write trigger only set by software, held
// - Write trigger low means nothing in progress
// - Write needs 55h then AAh key first
// - Read borrows second cycle, discards that instruction
// - Read data appears the cycle after access
// - Data registers hold until read or write
// - Protected segments are never modified
// - Four-word aligned blocks, never crossing boundaries
// - Block write erases sixteen, programs four words
// - First three words only fill the buffer
// - Low bits 11 erase and program the block
// - Software loads words in ascending order
// - Two idle cycles follow the write trigger
// - Core stalls during long write, clocks run
// - Execution resumes at third following instruction
// - Unchanged words are read back into buffer
// - Power-up clears write permission
// - Power-up timer blocks all writes
package fps_pkg;

  // ========================================================================
  // Device register indices on the core side.
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_KEY  = 3'h1;
  localparam logic [2:0] REG_ADRL = 3'h2;
  localparam logic [2:0] REG_ADRH = 3'h3;
  localparam logic [2:0] REG_DATL = 3'h4;
  localparam logic [2:0] REG_DATH = 3'h5;

  // ========================================================================
  // Control register fields and values.
  localparam int         CTRL_RD_BIT   = 0;
  localparam int         CTRL_WR_BIT   = 1;
  localparam int         CTRL_WRITE_PERMISSION_BIT = 2;
  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'hAA;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // ========================================================================
  // Array geometry.
  localparam int          ADDR_W      = 10;
  localparam int          WORD_W      = 14;
  localparam int          BLOCK_WORDS = 4;
  localparam int          ERASE_WORDS = 16;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;

  // ========================================================================
  // Timing.
  localparam int CLK_MHZ        = 200;
  localparam int WRITE_TIME_US  = 4000;
  localparam int PWRT_TIME_MS   = 64;
  localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  localparam int PWRT_CYCLES    = PWRT_TIME_MS * 1000 * CLK_MHZ;
  localparam int SETUP_CYCLES   = 2;
  localparam int CNT_W          = 24;

  // ========================================================================
  // Host Wishbone map.
  localparam logic [3:0] HOST_ACCESS = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam int         STAT_PEND   = 0;
  localparam int         STAT_STALL  = 1;
  localparam int         STAT_DROP   = 2;

endpackage : fps_pkg

/* inc/fps_if.sv */
// Register access link between the core and the flash sequencer.
// Both ends run on the same clock; the bench supplies nothing but wiring.
`timescale 1ns/1ps
`default_nettype none
interface fps_if;
  logic       acc_we;
  logic       acc_re;
  logic [2:0] acc_reg;
  logic [7:0] acc_wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       stall;
  logic       squash;

  modport dev  (input acc_we, acc_re, acc_reg, acc_wdata,
                output rdata, rvalid, stall, squash);
  modport core (output acc_we, acc_re, acc_reg, acc_wdata,
                input rdata, rvalid, stall, squash);
endinterface : fps_if
`default_nettype wire

/* rtl/fps_core.sv */
// Core end: turns Wishbone commands into single register accesses.
// Assumes software keeps key and trigger back to back and in block order.
`timescale 1ns/1ps
`default_nettype none
module fps_core (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Flash sequencer side
  fps_if.core              bus
);

  logic       pend_q;
  logic       dir_q;
  logic [2:0] reg_q;
  logic [7:0] wdata_q;
  logic       we_q;
  logic       re_q;
  logic [1:0] nop_q;
  logic       drop_q;
  logic [7:0] rd_q;
  logic       wb_req;
  logic       issue;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign issue  = pend_q && !we_q && !re_q && !bus.stall && nop_q == 2'h0;

  // ========================================================================
  // Wishbone slave, answered one cycle after the strobe.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i && wb_adr_i == fps_pkg::HOST_STATUS) begin
        wb_dat_o <= {16'h0000, rd_q, 5'h00, drop_q, bus.stall, pend_q};
      end
    end
  end

  // ========================================================================
  // Pending command, launched by a write to the access register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pend_q  <= 1'b0;
      dir_q   <= 1'b0;
      reg_q   <= 3'h0;
      wdata_q <= 8'h00;
    end else if (wb_req && wb_we_i && wb_adr_i == fps_pkg::HOST_ACCESS && !pend_q
                 && wb_sel_i == 4'hF) begin
      pend_q  <= 1'b1;
      dir_q   <= wb_dat_i[16];
      reg_q   <= wb_dat_i[2:0];
      wdata_q <= wb_dat_i[15:8];
    end else if (issue) begin
      pend_q <= 1'b0;
    end
  end

  // ========================================================================
  // One-cycle access strobes and the idle slots after a write trigger.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      we_q  <= 1'b0;
      re_q  <= 1'b0;
      nop_q <= 2'h0;
    end else begin
      we_q <= issue && dir_q;
      re_q <= issue && !dir_q;
      if (we_q && reg_q == fps_pkg::REG_CTRL && wdata_q[fps_pkg::CTRL_WR_BIT]) begin
        nop_q <= 2'(fps_pkg::SETUP_CYCLES);
      end else if (nop_q != 2'h0) begin
        nop_q <= nop_q - 1'b1;
      end
    end
  end

  // ========================================================================
  // Result capture and discarded-access flag.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      drop_q <= 1'b0;
      rd_q   <= 8'h00;
    end else begin
      if ((we_q || re_q) && (bus.squash || bus.stall)) begin
        drop_q <= 1'b1;
      end else if (issue) begin
        drop_q <= 1'b0;
      end
      if (bus.rvalid) begin
        rd_q <= bus.rdata;
      end
    end
  end

  assign bus.acc_we    = we_q;
  assign bus.acc_re    = re_q;
  assign bus.acc_reg   = reg_q;
  assign bus.acc_wdata = wdata_q;

endmodule : fps_core
`default_nettype wire

/* bench/fps_sva.sv */
// Link checks between the core end and the flash end of the sequencer.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ps
`default_nettype none
module fps_sva #(
  parameter int WRITE_CYCLES = fps_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       reset_i,
  // Link signals
  input wire logic       acc_we,
  input wire logic       acc_re,
  input wire logic [2:0] acc_reg,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       stall,
  input wire logic       squash
);
  int stall_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // Stall length counter
  always_ff @(posedge clock_i) begin
    if (reset_i || !stall) begin
      stall_q <= 0;
    end else begin
      stall_q <= stall_q + 1;
    end
  end

  // ==========================================================================
  // Assertions
  chk_squash_one: assert property (squash |=> !squash)
    else $error("squash longer than one cycle");
  chk_read_squash: assert property ($rose(squash) |-> $past(acc_we, 2) &&
    $past(acc_reg, 2) == fps_pkg::REG_CTRL && $past(acc_wdata[0], 2))
    else $error("squash without a read trigger");
  chk_rvalid_cause: assert property (rvalid |-> $past(acc_re))
    else $error("read data without a read access");
  chk_read_answer: assert property (acc_re && !stall && !squash |=> rvalid ##1 !rvalid)
    else $error("read access not answered once");
  chk_stall_length: assert property ($fell(stall) |-> stall_q == WRITE_CYCLES)
    else $error("long write stall of wrong length");
  chk_stall_cause: assert property ($rose(stall) |-> $past(acc_we, 3) &&
    $past(acc_reg, 3) == fps_pkg::REG_CTRL && $past(acc_wdata[1], 3))
    else $error("stall without a write trigger");
  chk_stall_quiet: assert property (stall |-> !(acc_we || acc_re))
    else $error("access during stall");
  chk_access_gap: assert property ((acc_we || acc_re) |=> !(acc_we || acc_re))
    else $error("accesses on adjacent cycles");
  chk_trigger_gap: assert property (acc_we && acc_reg == fps_pkg::REG_CTRL &&
    acc_wdata[1] |=> (!(acc_we || acc_re)) [*2])
    else $error("access too soon after write trigger");

  cov_long_write: cover property ($fell(stall));
  cov_flash_read: cover property ($rose(squash));
  cov_reg_read: cover property (rvalid);
endmodule : fps_sva
`default_nettype wire

/* bench/test_program_flash_self_write_sequencer.sv */
// Bench: a Wishbone host drives the core end, which drives the flash end.
// Assumes shortened write and power-up counts and one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_program_flash_self_write_sequencer;
  localparam int WRC = 20;
  localparam int PWC = 300;
  logic        clock_i;
  logic        reset_i;
  logic        cyc;
  logic        we;
  logic        ack;
  logic        busy;
  logic        pdone;
  logic [3:0]  adr;
  logic [3:0]  prot;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] st;
  logic [13:0] w;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          bcyc = 0;

  // ==========================================================================
  // Both ends and the checker
  fps_if bus ();
  fps_core u_fps_core (.clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .bus(bus));
  fps_flash #(.WRITE_CYCLES(WRC), .PWRT_CYCLES(PWC)) u_fps_flash (.clock_i(clock_i),
    .reset_i(reset_i), .bus(bus), .protect_seg_i(prot), .busy_o(busy), .pwrt_done_o(pdone));
  fps_sva #(.WRITE_CYCLES(WRC)) u_fps_sva (.clock_i(clock_i), .reset_i(reset_i),
    .acc_we(bus.acc_we), .acc_re(bus.acc_re), .acc_reg(bus.acc_reg),
    .acc_wdata(bus.acc_wdata), .rdata(bus.rdata), .rvalid(bus.rvalid), .stall(bus.stall),
    .squash(bus.squash));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (busy === 1'b1) bcyc++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wb(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc  <= 1'b1;
    we   <= w_en;
    adr  <= a;
    wdat <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    st = rdat;
    cyc <= 1'b0;
  endtask : wb

  // One register access on the link, then wait until it and any write have settled.
  // The pending bit clears before read data returns, so a last status read fetches it.
  task automatic acc(input logic w_en, input logic [2:0] r, input logic [7:0] d);
    int n;
    wb(1'b1, fps_pkg::HOST_ACCESS, {15'h0, w_en, d, 5'h0, r});
    n = 0;
    do begin
      wb(1'b0, fps_pkg::HOST_STATUS, 32'h0);
      n++;
    end while (st[1:0] !== 2'b00 && n < 60);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    wb(1'b0, fps_pkg::HOST_STATUS, 32'h0);
    check(32'(st[2:0]), 32'h0, "link settled");
    check(32'(busy), 32'h0, "busy settled");
  endtask : acc

  task automatic arm(input logic [7:0] k1, input logic [7:0] k2);
    acc(1'b1, fps_pkg::REG_CTRL, 8'h04);
    acc(1'b1, fps_pkg::REG_KEY, k1);
    acc(1'b1, fps_pkg::REG_KEY, k2);
    bcyc = 0;
    acc(1'b1, fps_pkg::REG_CTRL, 8'h06);
  endtask : arm

  task automatic setadr(input logic [9:0] a);
    acc(1'b1, fps_pkg::REG_ADRL, a[7:0]);
    acc(1'b1, fps_pkg::REG_ADRH, {6'h0, a[9:8]});
  endtask : setadr

  task automatic blk(input logic [9:0] a, input logic [13:0] d);
    for (int i = 0; i < 4; i++) begin
      setadr(a + 10'(i));
      acc(1'b1, fps_pkg::REG_DATL, 8'(d + 14'(i)));
      acc(1'b1, fps_pkg::REG_DATH, {2'h0, 6'((d + 14'(i)) >> 8)});
      arm(fps_pkg::KEY_FIRST, fps_pkg::KEY_SECOND);
      if (prot == 4'h0) check(32'(bcyc >= WRC), 32'(i == 3), "long write");
    end
  endtask : blk

  // Rewrite one word of a block; the other three are read back into the buffer first.
  task automatic patch(input logic [9:0] a, input logic [13:0] d);
    for (int i = 0; i < 4; i++) begin
      setadr({a[9:2], 2'(i)});
      if (2'(i) == a[1:0]) begin
        acc(1'b1, fps_pkg::REG_DATL, d[7:0]);
        acc(1'b1, fps_pkg::REG_DATH, {2'h0, d[13:8]});
      end else begin
        acc(1'b1, fps_pkg::REG_CTRL, 8'h01);
      end
      arm(fps_pkg::KEY_FIRST, fps_pkg::KEY_SECOND);
    end
  endtask : patch

  task automatic rdchk(input logic [9:0] a, input logic [13:0] exp);
    setadr(a);
    acc(1'b1, fps_pkg::REG_CTRL, 8'h01);
    acc(1'b0, fps_pkg::REG_DATL, 8'h00);
    w[7:0] = st[15:8];
    acc(1'b0, fps_pkg::REG_DATH, 8'h00);
    w[13:8] = st[13:8];
    check(32'(w), 32'(exp), "flash word");
  endtask : rdchk

  // ==========================================================================
  // Main sequence
  initial begin
    reset_i <= 1'b1;
    cyc     <= 1'b0;
    we      <= 1'b0;
    adr     <= 4'h0;
    wdat    <= 32'h0;
    prot    <= 4'h0;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h00, "ctrl after reset");
    arm(fps_pkg::KEY_FIRST, fps_pkg::KEY_SECOND);
    check(32'(pdone), 32'h0, "timer running");
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h04, "write while timer runs");
    for (int n = 0; n < 400 && pdone !== 1'b1; n++) @(posedge clock_i);
    check(32'(pdone), 32'h1, "timer expiry");
    arm(fps_pkg::KEY_SECOND, fps_pkg::KEY_FIRST);
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h04, "keys reversed");
    check(32'(bcyc), 32'h0, "keys reversed busy");
    blk(10'h000, 14'h1000);
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h04, "write done");
    blk(10'h004, 14'h2A00);
    blk(10'h300, 14'h0155);
    patch(10'h006, 14'h1234);
    rdchk(10'h000, fps_pkg::ERASED_WORD);
    rdchk(10'h004, 14'h2A00);
    rdchk(10'h007, 14'h2A03);
    rdchk(10'h005, 14'h2A01);
    rdchk(10'h006, 14'h1234);
    rdchk(10'h303, 14'h0158);
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h00, "read trigger cleared");
    acc(1'b1, fps_pkg::REG_ADRL, 8'h55);
    acc(1'b0, fps_pkg::REG_DATL, 8'h00);
    check(32'(st[15:8]), 32'h58, "data held");
    wb(1'b0, 4'h8, 32'h0);
    check(st, 32'h0, "unmapped read");
    prot <= 4'h8;
    blk(10'h300, 14'h3000);
    rdchk(10'h301, 14'h0156);
    acc(1'b1, fps_pkg::REG_CTRL, 8'h04);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    acc(1'b0, fps_pkg::REG_CTRL, 8'h00);
    check(32'(st[15:8]), 32'h00, "permission after reset");
    check(32'(pdone), 32'h0, "timer restarted");
    complete_run();
  end
endmodule : test_program_flash_self_write_sequencer
`default_nettype wire
